/* include/sbf_pkg.sv */
// What this block does
// RL1: Logical right shift moves bits down, zero into bit 7, updates Z C N V.
// RL2: Rotate left through carry: old carry to bit 0, bit 7 to carry, Z C N V.
// RL3: Rotate right through carry: old carry to bit 7, bit 0 to carry, Z C N V.
// RL4: Arithmetic right shift keeps bit 7, shifts bits 7..1 down, updates Z C N V.
// RL5: Bit store copies selected source bit into transfer flag, nothing else changes.
// RL6: Bit load writes transfer flag into selected destination bit, flags untouched.
// RL7: Set overflow forces V to one, no other flag moves, one cycle.
// RL8: Clear overflow forces V to zero, no other flag moves, one cycle.
// RL9: Set signed forces S to one, no other flag moves, one cycle.
// RL10: Clear signed forces S to zero, no other flag moves, one cycle.
// RL11: Set half carry forces H to one, no other flag moves, one cycle.
// RL12: Clear half carry forces H to zero, no other flag moves.
// RL13: Nibble swap exchanges upper and lower nibbles, no flag changes, one cycle.
// RL14: Indexed and dedicated flag set/clear write the chosen status bit, one cycle.
package sbf_pkg;

  localparam int unsigned DATA_W = 8;

  // Operation codes from the decoder; codes above the last are illegal
  typedef enum logic [4:0] {
    no_op                     = 5'h00,
    logical_right_shift_op    = 5'h01,
    rotate_left_carry_op      = 5'h02,
    rotate_right_carry_op     = 5'h03,
    arithmetic_right_shift_op = 5'h04,
    nibble_swap_op            = 5'h05,
    indexed_flag_set_op       = 5'h06,
    indexed_flag_clear_op     = 5'h07,
    reg_bit_to_transfer_op    = 5'h08,
    transfer_to_reg_bit_op    = 5'h09,
    carry_set_op              = 5'h0A,
    carry_clear_op            = 5'h0B,
    negative_set_op           = 5'h0C,
    negative_clear_op         = 5'h0D,
    zero_flag_set_op          = 5'h0E,
    zero_flag_clear_op        = 5'h0F,
    global_irq_enable_op      = 5'h10,
    global_irq_disable_op     = 5'h11,
    signed_flag_set_op        = 5'h12,
    signed_flag_clear_op      = 5'h13,
    overflow_set_op           = 5'h14,
    overflow_clear_op         = 5'h15,
    transfer_flag_set_op      = 5'h16,
    transfer_flag_clear_op    = 5'h17,
    half_carry_set_op         = 5'h18,
    half_carry_clear_op       = 5'h19
  } sbf_op_t;

  // Status bit positions
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_S = 3'h4;
  localparam logic [2:0] FLG_H = 3'h5;
  localparam logic [2:0] FLG_T = 3'h6;
  localparam logic [2:0] FLG_I = 3'h7;

  // Register port map and reset values
  localparam logic [1:0] REG_STATUS_OFS = 2'h0;
  localparam logic [1:0] REG_RESULT_OFS = 2'h1;
  localparam logic [7:0] STATUS_RST     = 8'h00;
  localparam logic [7:0] DATA_ZERO      = 8'h00;
  localparam logic [4:0] ADDR_ZERO      = 5'h00;

endpackage : sbf_pkg

/* include/sbf_alu_if.sv */
interface sbf_alu_if;
  import sbf_pkg::*;

  sbf_op_t    op;
  logic [7:0] opnd;
  logic [2:0] bit_sel;
  logic [7:0] status;
  logic [7:0] res;
  logic       res_we;
  logic       cout;
  logic [7:0] status_nxt;

  modport top   (output op, opnd, bit_sel, status, input res, res_we, status_nxt);
  modport shift (input op, opnd, bit_sel, status, output res, res_we, cout);
  modport flag  (input op, opnd, bit_sel, status, res, res_we, cout, output status_nxt);
endinterface : sbf_alu_if

/* logic/sbf_shift_unit.sv */
module sbf_shift_unit
  import sbf_pkg::*;
(
  // Operand side
  sbf_alu_if.shift alu
);

  // Result datapath; ops without a data result raise no write-back
  always_comb
  begin
    alu.res    = alu.opnd;
    alu.res_we = 1'b1;
    alu.cout   = 1'b0;
    case (alu.op)
      logical_right_shift_op:
      begin
        alu.res  = {1'b0, alu.opnd[7:1]};                  // [RL1]
        alu.cout = alu.opnd[0];
      end
      rotate_left_carry_op:
      begin
        alu.res  = {alu.opnd[6:0], alu.status[FLG_C]};     // [RL2]
        alu.cout = alu.opnd[7];
      end
      rotate_right_carry_op:
      begin
        alu.res  = {alu.status[FLG_C], alu.opnd[7:1]};     // [RL3]
        alu.cout = alu.opnd[0];
      end
      arithmetic_right_shift_op:
      begin
        alu.res  = {alu.opnd[7], alu.opnd[7:1]};           // [RL4]
        alu.cout = alu.opnd[0];
      end
      nibble_swap_op:         alu.res = {alu.opnd[3:0], alu.opnd[7:4]}; // [RL13]
      transfer_to_reg_bit_op: alu.res[alu.bit_sel] = alu.status[FLG_T]; // [RL6]
      default: alu.res_we = 1'b0;
    endcase
  end

endmodule : sbf_shift_unit

/* logic/sbf_flag_unit.sv */
module sbf_flag_unit
  import sbf_pkg::*;
(
  // Operand side
  sbf_alu_if.flag alu
);

  logic neg;

  assign neg = alu.res[7];

  // Status next value; anything not named keeps its bit
  always_comb
  begin
    alu.status_nxt = alu.status;
    case (alu.op)
      logical_right_shift_op, rotate_left_carry_op, rotate_right_carry_op,
      arithmetic_right_shift_op:
      begin
        // Shifts touch only Z C N V; V is N xor C [RL1] [RL2] [RL3] [RL4]
        alu.status_nxt[FLG_Z] = (alu.res == DATA_ZERO);
        alu.status_nxt[FLG_C] = alu.cout;
        alu.status_nxt[FLG_N] = neg;
        alu.status_nxt[FLG_V] = neg ^ alu.cout;
      end
      reg_bit_to_transfer_op: alu.status_nxt[FLG_T] = alu.opnd[alu.bit_sel]; // [RL5]
      indexed_flag_set_op:    alu.status_nxt[alu.bit_sel] = 1'b1;          // [RL14]
      indexed_flag_clear_op:  alu.status_nxt[alu.bit_sel] = 1'b0;          // [RL14]
      carry_set_op:           alu.status_nxt[FLG_C] = 1'b1;                // [RL14]
      carry_clear_op:         alu.status_nxt[FLG_C] = 1'b0;                // [RL14]
      negative_set_op:        alu.status_nxt[FLG_N] = 1'b1;                // [RL14]
      negative_clear_op:      alu.status_nxt[FLG_N] = 1'b0;                // [RL14]
      zero_flag_set_op:       alu.status_nxt[FLG_Z] = 1'b1;                // [RL14]
      zero_flag_clear_op:     alu.status_nxt[FLG_Z] = 1'b0;                // [RL14]
      global_irq_enable_op:   alu.status_nxt[FLG_I] = 1'b1;                // [RL14]
      global_irq_disable_op:  alu.status_nxt[FLG_I] = 1'b0;                // [RL14]
      transfer_flag_set_op:   alu.status_nxt[FLG_T] = 1'b1;                // [RL14]
      transfer_flag_clear_op: alu.status_nxt[FLG_T] = 1'b0;                // [RL14]
      overflow_set_op:        alu.status_nxt[FLG_V] = 1'b1;                // [RL7]
      overflow_clear_op:      alu.status_nxt[FLG_V] = 1'b0;                // [RL8]
      signed_flag_set_op:     alu.status_nxt[FLG_S] = 1'b1;                // [RL9]
      signed_flag_clear_op:   alu.status_nxt[FLG_S] = 1'b0;                // [RL10]
      half_carry_set_op:      alu.status_nxt[FLG_H] = 1'b1;                // [RL11]
      half_carry_clear_op:    alu.status_nxt[FLG_H] = 1'b0;                // [RL12]
      default:                alu.status_nxt = alu.status;
    endcase
  end

endmodule : sbf_flag_unit

/* logic/sbf_datapath.sv */
module sbf_datapath
  import sbf_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Decoded operation
  input  wire logic             op_valid,
  input  wire sbf_pkg::sbf_op_t op_code,
  input  wire logic [4:0]       op_dst,
  input  wire logic [2:0]       op_bit,
  input  wire logic [7:0]       rd_data,
  input  wire logic [7:0]       source_register,
  // Write back to the register file
  output logic                  wb_we_r,
  output logic [4:0]            wb_addr_r,
  output logic [7:0]            wb_data_r,
  // Status flags
  output logic [7:0]            status_register_r,
  // Software register port
  input  wire logic [1:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [7:0]            reg_rdata_r
);

  sbf_alu_if alu ();

  sbf_op_t    op_eff;
  logic       sw_status_wr;
  logic [7:0] result_r;
  logic [7:0] result_nxt;
  logic       wb_we_nxt;
  logic [4:0] wb_addr_nxt;
  logic [7:0] wb_data_nxt;
  logic [7:0] status_register_nxt;
  logic [7:0] reg_rdata_nxt;

  // An idle cycle is a no-op, so stale decoder codes cannot move flags
  assign op_eff       = op_valid ? op_code : no_op;
  assign sw_status_wr = reg_wr && (reg_addr == REG_STATUS_OFS);

  // Operands into the units; bit store reads the source register
  assign alu.op      = op_eff;
  assign alu.opnd    = (op_eff == reg_bit_to_transfer_op) ? source_register : rd_data;
  assign alu.bit_sel = op_bit;
  assign alu.status  = status_register_r;

  sbf_shift_unit u_shift (
    .alu (alu.shift)
  );

  sbf_flag_unit u_flag (
    .alu (alu.flag)
  );

  // Datapath next values
  always_comb
  begin
    wb_we_nxt   = alu.res_we;
    wb_addr_nxt = alu.res_we ? op_dst : wb_addr_r;
    wb_data_nxt = alu.res_we ? alu.res : wb_data_r;
    result_nxt  = alu.res_we ? alu.res : result_r;
    // Software write wins so a flag restore cannot be undone by a stray op
    status_register_nxt = sw_status_wr ? reg_wdata : alu.status_nxt;
  end

  // Datapath registers; every op lands in exactly one cycle
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wb_we_r           <= 1'b0;
      wb_addr_r         <= ADDR_ZERO;
      wb_data_r         <= DATA_ZERO;
      result_r          <= DATA_ZERO;
      status_register_r <= STATUS_RST;
    end
    else
    begin
      wb_we_r           <= wb_we_nxt;
      wb_addr_r         <= wb_addr_nxt;
      wb_data_r         <= wb_data_nxt;
      result_r          <= result_nxt;
      status_register_r <= status_register_nxt;
    end
  end

  // Read data shows only in the cycle after the strobe
  always_comb
  begin
    reg_rdata_nxt = DATA_ZERO;
    if (reg_rd)
    begin
      case (reg_addr)
        REG_STATUS_OFS: reg_rdata_nxt = status_register_r;
        REG_RESULT_OFS: reg_rdata_nxt = result_r;
        default:        reg_rdata_nxt = DATA_ZERO;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      reg_rdata_r <= DATA_ZERO;
    end
    else
    begin
      reg_rdata_r <= reg_rdata_nxt;
    end
  end

  // Checks; an op is judged only when software did not write status too
  logic live;

  assign live = op_valid && !sw_status_wr;

  property p_shift_right;
    @(posedge clk) disable iff (!nrst)
    live && op_code == logical_right_shift_op |=> wb_we_r
      && wb_data_r == {1'b0, $past(rd_data[7:1])}
      && status_register_r[FLG_C] == $past(rd_data[0])
      && !status_register_r[FLG_N]
      && status_register_r[FLG_V] == $past(rd_data[0])
      && status_register_r[FLG_Z] == ($past(rd_data[7:1]) == 7'h00);
  endproperty
  a_shift_right: assert property (p_shift_right) else $error("logical shift wrong"); // [RL1]

  property p_rot_left;
    @(posedge clk) disable iff (!nrst)
    live && op_code == rotate_left_carry_op |=> wb_we_r
      && wb_data_r == {$past(rd_data[6:0]), $past(status_register_r[FLG_C])}
      && status_register_r[FLG_C] == $past(rd_data[7])
      && status_register_r[FLG_N] == $past(rd_data[6]);
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("rotate left wrong"); // [RL2]

  property p_rot_right;
    @(posedge clk) disable iff (!nrst)
    live && op_code == rotate_right_carry_op |=> wb_we_r
      && wb_data_r == {$past(status_register_r[FLG_C]), $past(rd_data[7:1])}
      && status_register_r[FLG_C] == $past(rd_data[0])
      && status_register_r[FLG_V]
         == ($past(status_register_r[FLG_C]) ^ $past(rd_data[0]));
  endproperty
  a_rot_right: assert property (p_rot_right) else $error("rotate right wrong"); // [RL3]

  property p_arith_right;
    @(posedge clk) disable iff (!nrst)
    live && op_code == arithmetic_right_shift_op |=> wb_we_r
      && wb_data_r == {$past(rd_data[7]), $past(rd_data[7:1])}
      && status_register_r[FLG_C] == $past(rd_data[0])
      && status_register_r[FLG_N] == $past(rd_data[7]);
  endproperty
  a_arith_right: assert property (p_arith_right) else $error("arithmetic shift wrong"); // [RL4]

  property p_bit_store;
    @(posedge clk) disable iff (!nrst)
    live && op_code == reg_bit_to_transfer_op |=> !wb_we_r
      && status_register_r[FLG_T] == $past(source_register[op_bit])
      && (status_register_r & 8'hBF) == ($past(status_register_r) & 8'hBF);
  endproperty
  a_bit_store: assert property (p_bit_store) else $error("bit store wrong"); // [RL5]

  property p_bit_load;
    @(posedge clk) disable iff (!nrst)
    live && op_code == transfer_to_reg_bit_op |=> wb_we_r
      && wb_data_r[$past(op_bit)] == $past(status_register_r[FLG_T])
      && status_register_r == $past(status_register_r);
  endproperty
  a_bit_load: assert property (p_bit_load) else $error("bit load wrong"); // [RL6]

  property p_ovf_set;
    @(posedge clk) disable iff (!nrst)
    live && op_code == overflow_set_op |=> status_register_r
      == ($past(status_register_r) | 8'h08);
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("set overflow wrong"); // [RL7]

  property p_ovf_clear;
    @(posedge clk) disable iff (!nrst)
    live && op_code == overflow_clear_op |=> status_register_r
      == ($past(status_register_r) & 8'hF7);
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("clear overflow wrong"); // [RL8]

  property p_sign_set;
    @(posedge clk) disable iff (!nrst)
    live && op_code == signed_flag_set_op |=> status_register_r
      == ($past(status_register_r) | 8'h10);
  endproperty
  a_sign_set: assert property (p_sign_set) else $error("set signed wrong"); // [RL9]

  property p_sign_clear;
    @(posedge clk) disable iff (!nrst)
    live && op_code == signed_flag_clear_op |=> status_register_r
      == ($past(status_register_r) & 8'hEF);
  endproperty
  a_sign_clear: assert property (p_sign_clear) else $error("clear signed wrong"); // [RL10]

  property p_half_set;
    @(posedge clk) disable iff (!nrst)
    live && op_code == half_carry_set_op |=> status_register_r
      == ($past(status_register_r) | 8'h20);
  endproperty
  a_half_set: assert property (p_half_set) else $error("set half carry wrong"); // [RL11]

  property p_half_clear;
    @(posedge clk) disable iff (!nrst)
    live && op_code == half_carry_clear_op |=> status_register_r
      == ($past(status_register_r) & 8'hDF);
  endproperty
  a_half_clear: assert property (p_half_clear) else $error("clear half carry wrong"); // [RL12]

  property p_swap;
    @(posedge clk) disable iff (!nrst)
    live && op_code == nibble_swap_op |=> wb_we_r
      && wb_data_r == {$past(rd_data[3:0]), $past(rd_data[7:4])}
      && status_register_r == $past(status_register_r);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong"); // [RL13]

  property p_idx_set;
    @(posedge clk) disable iff (!nrst)
    live && op_code == indexed_flag_set_op |=> status_register_r[$past(op_bit)] && !wb_we_r;
  endproperty
  a_idx_set: assert property (p_idx_set) else $error("indexed set wrong"); // [RL14]

  property p_idx_clear;
    @(posedge clk) disable iff (!nrst)
    live && op_code == indexed_flag_clear_op |=> !status_register_r[$past(op_bit)]
      && !wb_we_r;
  endproperty
  a_idx_clear: assert property (p_idx_clear) else $error("indexed clear wrong"); // [RL14]

  // Dedicated forms; each must leave the other seven flags alone
  property p_carry_set;
    @(posedge clk) disable iff (!nrst)
    live && op_code == carry_set_op |=> status_register_r
      == ($past(status_register_r) | 8'h01);
  endproperty
  a_carry_set: assert property (p_carry_set) else $error("set carry wrong"); // [RL14]

  property p_carry_clear;
    @(posedge clk) disable iff (!nrst)
    live && op_code == carry_clear_op |=> status_register_r
      == ($past(status_register_r) & 8'hFE);
  endproperty
  a_carry_clear: assert property (p_carry_clear) else $error("clear carry wrong"); // [RL14]

  property p_neg_set;
    @(posedge clk) disable iff (!nrst)
    live && op_code == negative_set_op |=> status_register_r
      == ($past(status_register_r) | 8'h04);
  endproperty
  a_neg_set: assert property (p_neg_set) else $error("set negative wrong"); // [RL14]

  property p_neg_clear;
    @(posedge clk) disable iff (!nrst)
    live && op_code == negative_clear_op |=> status_register_r
      == ($past(status_register_r) & 8'hFB);
  endproperty
  a_neg_clear: assert property (p_neg_clear) else $error("clear negative wrong"); // [RL14]

  property p_zero_set;
    @(posedge clk) disable iff (!nrst)
    live && op_code == zero_flag_set_op |=> status_register_r
      == ($past(status_register_r) | 8'h02);
  endproperty
  a_zero_set: assert property (p_zero_set) else $error("set zero wrong"); // [RL14]

  property p_zero_clear;
    @(posedge clk) disable iff (!nrst)
    live && op_code == zero_flag_clear_op |=> status_register_r
      == ($past(status_register_r) & 8'hFD);
  endproperty
  a_zero_clear: assert property (p_zero_clear) else $error("clear zero wrong"); // [RL14]

  property p_irq_on;
    @(posedge clk) disable iff (!nrst)
    live && op_code == global_irq_enable_op |=> status_register_r
      == ($past(status_register_r) | 8'h80);
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq enable wrong"); // [RL14]

  property p_irq_off;
    @(posedge clk) disable iff (!nrst)
    live && op_code == global_irq_disable_op |=> status_register_r
      == ($past(status_register_r) & 8'h7F);
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq disable wrong"); // [RL14]

  property p_tflag_set;
    @(posedge clk) disable iff (!nrst)
    live && op_code == transfer_flag_set_op |=> status_register_r
      == ($past(status_register_r) | 8'h40);
  endproperty
  a_tflag_set: assert property (p_tflag_set) else $error("set transfer wrong"); // [RL14]

  property p_tflag_clear;
    @(posedge clk) disable iff (!nrst)
    live && op_code == transfer_flag_clear_op |=> status_register_r
      == ($past(status_register_r) & 8'hBF);
  endproperty
  a_tflag_clear: assert property (p_tflag_clear) else $error("clear transfer wrong"); // [RL14]

  // Reset must leave write enable, write data, status and read data at idle values one edge later
  property p_reset_clears;
    @(posedge clk) !nrst |=> !wb_we_r && wb_data_r == DATA_ZERO
      && status_register_r == STATUS_RST && reg_rdata_r == DATA_ZERO;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left state");

endmodule : sbf_datapath

/* dv/sbf_regfile_model.sv */
module sbf_regfile_model
(
  // Clock
  input  wire logic       clk,
  // Read indices from the decoder side
  input  wire logic [4:0] rd_idx,
  input  wire logic [4:0] rs_idx,
  output logic [7:0]      rd_val,
  output logic [7:0]      rs_val,
  // Write back from the datapath
  input  wire logic       wb_we,
  input  wire logic [4:0] wb_addr,
  input  wire logic [7:0] wb_data,
  // Bench preload
  input  wire logic       pre_we,
  input  wire logic [4:0] pre_addr,
  input  wire logic [7:0] pre_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_r [32];

  // Forward a write still in flight, else back-to-back ops read stale data
  always_comb
  begin
    rd_val = (wb_we && wb_addr == rd_idx) ? wb_data : mem_r[rd_idx];
    rs_val = (wb_we && wb_addr == rs_idx) ? wb_data : mem_r[rs_idx];
  end

  // Preload only happens while the datapath is idle
  always_ff @(posedge clk)
  begin
    if (pre_we)
      mem_r[pre_addr] <= pre_data;
    else if (wb_we)
      mem_r[wb_addr] <= wb_data;
  end
endmodule : sbf_regfile_model

/* dv/test_shift_bit_flag_datapath.sv */
module test_shift_bit_flag_datapath;
  timeunit 1ns;
  timeprecision 1ns;
  import sbf_pkg::*;

  // Design and partner wiring
  logic       clk = 1'b0;
  logic       nrst, op_valid, wb_we_r, reg_wr, reg_rd, pre_we;
  sbf_op_t    op_code;
  logic [4:0] op_dst, src_idx, wb_addr_r, pre_addr;
  logic [2:0] op_bit;
  logic [1:0] reg_addr;
  logic [7:0] rd_data, source_register, wb_data_r, status_register_r;
  logic [7:0] reg_wdata, reg_rdata_r, pre_data;
  // Reference model state
  int         m_reg [32];
  int         m_status = 0, m_res = 0, e_addr = 0, e_we = 0, e_rd = 0;
  int         errors = 0, samples_checked = 0, seed = 52, i;

  always #25 clk = ~clk;

  sbf_datapath i_dut (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
    .op_dst(op_dst), .op_bit(op_bit), .rd_data(rd_data), .source_register(source_register),
    .wb_we_r(wb_we_r), .wb_addr_r(wb_addr_r), .wb_data_r(wb_data_r),
    .status_register_r(status_register_r), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));

  sbf_regfile_model i_rf (.clk(clk), .rd_idx(op_dst), .rs_idx(src_idx), .rd_val(rd_data),
    .rs_val(source_register), .wb_we(wb_we_r), .wb_addr(wb_addr_r), .wb_data(wb_data_r),
    .pre_we(pre_we), .pre_addr(pre_addr), .pre_data(pre_data));

  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction : rnd

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One cycle of stimulus, then the model steps at the taking edge
  task automatic step(input int v, c, d, s, b, wr, rd, a, wd);
    int x, r, f, w;
    int fl[8];
    begin
      fl = '{FLG_C, FLG_N, FLG_Z, FLG_I, FLG_S, FLG_V, FLG_T, FLG_H};
      op_valid <= v[0];
      op_code <= sbf_op_t'(c[4:0]);
      op_dst <= d[4:0];
      src_idx <= s[4:0];
      op_bit <= b[2:0];
      reg_wr <= wr[0];
      reg_rd <= rd[0];
      reg_addr <= a[1:0];
      reg_wdata <= wd[7:0];
      @(posedge clk);
      x = m_reg[d];
      f = m_status;
      r = x;
      w = 0;
      e_rd = !rd ? 0 : (a == 0) ? m_status : (a == 1) ? m_res : 0;
      if (v)
      begin
        case (c)
          logical_right_shift_op:
          begin
            r = x >> 1;
            f[FLG_C] = x[0];
          end
          rotate_left_carry_op:
          begin
            r = ((x << 1) | f[FLG_C]) & 255;
            f[FLG_C] = x[7];
          end
          rotate_right_carry_op:
          begin
            r = (x >> 1) | (f[FLG_C] ? 128 : 0);
            f[FLG_C] = x[0];
          end
          arithmetic_right_shift_op:
          begin
            r = (x >> 1) | (x & 128);
            f[FLG_C] = x[0];
          end
          nibble_swap_op: r = ((x & 15) << 4) | (x >> 4);
          indexed_flag_set_op, indexed_flag_clear_op: f[b] = (c == indexed_flag_set_op);
          reg_bit_to_transfer_op: f[FLG_T] = m_reg[s][b];
          transfer_to_reg_bit_op: r[b] = f[FLG_T];
          default:
            if (c >= carry_set_op && c <= half_carry_clear_op)
              f[fl[(c - carry_set_op) / 2]] = (c % 2 == 0);
        endcase
        w = (c >= logical_right_shift_op && c <= nibble_swap_op) || c == transfer_to_reg_bit_op;
      end
      if (v && c >= logical_right_shift_op && c <= arithmetic_right_shift_op)
      begin
        f[FLG_Z] = (r == 0);
        f[FLG_N] = r[7];
        f[FLG_V] = f[FLG_N] ^ f[FLG_C];
      end
      m_status = (wr && a == 0) ? wd : f;
      if (w)
      begin
        m_reg[d] = r;
        m_res = r;
        e_addr = d;
      end
      e_we = w;
    end
  endtask : step

  // Every settled cycle with nrst high is compared with the model
  always @(posedge clk)
  begin
    #1;
    if (nrst === 1'b1)
    begin
      chk({7'h0, wb_we_r}, e_we[7:0]);
      chk({3'h0, wb_addr_r}, e_addr[7:0]);
      chk(wb_data_r, m_res[7:0]);
      chk(status_register_r, m_status[7:0]);
      chk(reg_rdata_r, e_rd[7:0]);
    end
    e_we = 0;
    e_rd = 0;
  end

  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // Run needs about 500 cycles
  initial
  begin
    #100_000;
    errors++;
    results();
  end

  initial
  begin
    {nrst, op_valid, reg_wr, reg_rd, pre_we} = 5'h00;
    {op_dst, src_idx, op_bit, reg_addr, reg_wdata, pre_addr, pre_data} = 36'h0_0000_0000;
    op_code = no_op;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 32; i++)
    begin
      m_reg[i] = rnd(256);
      pre_we <= 1'b1;
      pre_addr <= i[4:0];
      pre_data <= m_reg[i][7:0];
      @(posedge clk);
    end
    pre_we <= 1'b0;
    // Every code once, illegal ones included
    for (i = 0; i < 32; i++)
      step(1, i, rnd(32), rnd(32), rnd(8), 0, 0, 0, 0);
    // Back-to-back random ops, op_valid sometimes low
    repeat (400)
      step(rnd(4) != 0, rnd(32), rnd(32), rnd(32), rnd(8), 0, 0, 0, 0);
    // A reset in mid-run clears outputs and flags, not the register file
    op_valid <= 1'b0;
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    m_status = 0;
    m_res = 0;
    e_addr = 0;
    // Write then read every offset, unmapped ones too
    for (i = 0; i < 4; i++)
    begin
      step(0, 0, 0, 0, 0, 1, 0, i, rnd(256));
      step(0, 0, 0, 0, 0, 0, 1, i, 0);
    end
    // A software write beats a same-cycle flag op
    step(1, overflow_set_op, 0, 0, 0, 1, 0, 0, 8'h00);
    step(1, logical_right_shift_op, 3, 0, 0, 1, 0, 1, 8'h5a);
    step(0, 0, 0, 0, 0, 0, 1, 1, 0);
    step(0, 0, 0, 0, 0, 0, 0, 0, 0);
    @(posedge clk);
    results();
  end
endmodule : test_shift_bit_flag_datapath
